// *** ccsr_top.v ***
// Operation
// (R1) control bit 0 enables charging, resets 1
// (R2) bits 4:1 pick constant current, OTP default
// (R3) bits 6:5 pick trickle current, OTP default
// (R4) control bit 7 enables overvoltage protection
// (R5) end-of-charge adjust bits 3:2, reset 00
// (R6) secondary bit 3 disables resume, reset 0
// (R7) secondary bit 4 selects 4.2 V termination
// (R8) secondary bit 6 selects high overvoltage threshold
// (R9) secondary bit 7 reads live overvoltage condition
// (R10) status bit 0 shows adapter detected
// (R11) status bit 1 shows charger operating
// (R12) status bit 3 shows trickle mode
// (R13) status bit 4 shows top-off mode
// (R14) status bit 5 end of charge, cleared by disable
// (R15) status bit 6 no battery, auto cleared
// (R16) overvoltage with protection clears enable, signals
// (R17) top-off current at threshold ends charge cycle
// (R18) resume restarts constant current after 100 ms
// (R19) two quick drops after end set no-battery
// (R20) unused bits read zero, ignore writes
`timescale 1ns/1ps
`include "ccsr_defs.vh"
module ccsr_top #(
  parameter [`CCSR_TMR_W-1:0] DEAD_CYCLES = `CCSR_DEAD_TIME_MS * `CCSR_CLK_KHZ,
  parameter [`CCSR_TMR_W-1:0] BATTERY_ABSENT_FLAG_CYCLES = `CCSR_BATTERY_ABSENT_FLAG_TIME_MS * `CCSR_CLK_KHZ
) (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [3:0] otp_cc_current_sel,
  input wire [1:0] otp_precharge_current_sel,
  input wire adapter_detect_in,
  input wire vbat_below_uvlo_in,
  input wire vbat_at_term_in,
  input wire current_at_term_in,
  input wire overvoltage_in,
  input wire vbat_resume_low_in,
  input wire battery_ok_in,
  output reg charger_on,
  output reg [3:0] cc_current_sel,
  output reg [1:0] precharge_current_sel,
  output reg [1:0] termination_current_adj,
  output reg ovp_enable,
  output reg high_term_voltage_sel,
  output reg ovp_high_threshold_sel,
  output reg ovp_event
);
  ////////////////////////////////////////////////////////////////
  // charge sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_TRICKLE = 3'h1;
  localparam [2:0] ST_CC = 3'h2;
  localparam [2:0] ST_CV = 3'h3;
  localparam [2:0] ST_EOC = 3'h4;
  localparam [2:0] ST_DEAD = 3'h5;

  reg charge_enable; // software enable, cleared by protection
  reg resume_disable; // 1 holds the charger in end of charge
  reg otp_pending; // defaults still to be fetched after reset
  reg [2:0] state; // sequencer state
  reg [2:0] next_state; // sequencer next state
  reg eoc_flag; // sticky end-of-charge flag
  reg [`CCSR_TMR_W-1:0] dead_count; // resume dead time counter
  reg drop_seen; // previous sampled drop level
  wire [`CCSR_IN_W-1:0] raw_in; // comparator levels from the analog side
  wire [`CCSR_IN_W-1:0] syn_in; // the same after two flops
  wire adapter_present_flag; // adapter detected
  wire ovp_flag; // overvoltage right now
  wire vbat_drop; // rising edge of resume-low comparator
  wire battery_absent_flag; // from the no-battery timer
  wire charging_active_flag; // charger operating
  wire trickle_flag; // trickle charge running
  wire topoff_mode_flag; // constant-voltage top-off
  wire wr_pri; // write to primary control
  wire ovp_trip; // protection trips this cycle

  ////////////////////////////////////////////////////////////////
  // comparator inputs come from the analog domain
  assign raw_in = {battery_ok_in, vbat_resume_low_in, overvoltage_in,
                   current_at_term_in, vbat_at_term_in, vbat_below_uvlo_in,
                   adapter_detect_in};

  ccsr_sync #(
    .W(`CCSR_IN_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign adapter_present_flag = syn_in[`CCSR_IN_ADAPTER]; // R10
  assign ovp_flag = syn_in[`CCSR_IN_OVP]; // R9
  assign vbat_drop = syn_in[`CCSR_IN_VDROP] & ~drop_seen;

  // edge memory for the drop comparator
  always @(posedge clk) begin
    if (rst) begin
      drop_seen <= 1'b0;
    end else begin
      drop_seen <= syn_in[`CCSR_IN_VDROP];
    end
  end

  ////////////////////////////////////////////////////////////////
  // protection: only an enabled charger can be shut down
  assign ovp_trip = ovp_flag & ovp_enable & charge_enable; // R16
  assign wr_pri = reg_wr && (reg_addr == `CCSR_ADDR_CTRL_PRI);

  // primary control register; the protection clear beats a
  // software write in the same cycle so a trip is never undone
  always @(posedge clk) begin
    if (rst) begin
      charge_enable <= `CCSR_RST_EN; // R1
      ovp_enable <= `CCSR_RST_OVPEN; // R4
      otp_pending <= 1'b1;
      cc_current_sel <= 4'h0;
      precharge_current_sel <= 2'h0;
      ovp_event <= 1'b0;
    end else begin
      otp_pending <= 1'b0;
      ovp_event <= ovp_trip; // R16
      if (otp_pending) begin
        // defaults are caught the cycle after reset release
        cc_current_sel <= otp_cc_current_sel; // R2
        precharge_current_sel <= otp_precharge_current_sel; // R3
      end else if (wr_pri) begin
        cc_current_sel <= reg_wdata[`CCSR_PRI_CC_HI:`CCSR_PRI_CC_LO]; // R2
        precharge_current_sel <= reg_wdata[`CCSR_PRI_PRE_HI:`CCSR_PRI_PRE_LO]; // R3
      end
      if (wr_pri) begin
        ovp_enable <= reg_wdata[`CCSR_PRI_OVPEN_BIT]; // R4
      end
      if (ovp_trip) begin
        charge_enable <= 1'b0; // R16
      end else if (wr_pri) begin
        charge_enable <= reg_wdata[`CCSR_PRI_EN_BIT]; // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // termination adjust and secondary control registers
  always @(posedge clk) begin
    if (rst) begin
      termination_current_adj <= `CCSR_RST_ADJ; // R5
      resume_disable <= `CCSR_RST_RESDIS; // R6
      high_term_voltage_sel <= `CCSR_RST_HITERM; // R7
      ovp_high_threshold_sel <= `CCSR_RST_OVPHI; // R8
    end else begin
      if (reg_wr && (reg_addr == `CCSR_ADDR_TERM_ADJ)) begin
        // code 10 is stored as written; software must avoid it
        termination_current_adj <= reg_wdata[`CCSR_ADJ_HI:`CCSR_ADJ_LO]; // R5
      end
      if (reg_wr && (reg_addr == `CCSR_ADDR_CTRL_SEC)) begin
        resume_disable <= reg_wdata[`CCSR_SEC_RESDIS_BIT]; // R6
        high_term_voltage_sel <= reg_wdata[`CCSR_SEC_HITERM_BIT]; // R7
        ovp_high_threshold_sel <= reg_wdata[`CCSR_SEC_OVPHI_BIT]; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // charge sequencer next state
  always @* begin
    next_state = state;
    if (!charge_enable || !adapter_present_flag) begin
      // losing the adapter or the enable aborts any phase
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (syn_in[`CCSR_IN_UVLO]) begin
            next_state = ST_TRICKLE;
          end else begin
            next_state = ST_CC;
          end
        end
        ST_TRICKLE: begin
          // deeply discharged cell stays at trickle until uvlo clears
          if (!syn_in[`CCSR_IN_UVLO]) begin
            next_state = ST_CC;
          end
        end
        ST_CC: begin
          if (syn_in[`CCSR_IN_TERMV]) begin
            next_state = ST_CV;
          end
        end
        ST_CV: begin
          if (syn_in[`CCSR_IN_ILOW]) begin
            next_state = ST_EOC; // R17
          end
        end
        ST_EOC: begin
          if (vbat_drop && !resume_disable) begin
            next_state = ST_DEAD; // R6 R18
          end
        end
        ST_DEAD: begin
          // the pause keeps an empty socket from oscillating fast
          if (dead_count >= DEAD_CYCLES - {{(`CCSR_TMR_W-1){1'b0}}, 1'b1}) begin
            next_state = ST_CC; // R18
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer state, dead timer and end-of-charge flag
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      dead_count <= {`CCSR_TMR_W{1'b0}};
      eoc_flag <= 1'b0;
      charger_on <= 1'b0;
    end else begin
      state <= next_state;
      charger_on <= (next_state == ST_TRICKLE) || (next_state == ST_CC) ||
                    (next_state == ST_CV);
      if (state == ST_DEAD) begin
        dead_count <= dead_count + {{(`CCSR_TMR_W-1){1'b0}}, 1'b1};
      end else begin
        dead_count <= {`CCSR_TMR_W{1'b0}};
      end
      if (!charge_enable) begin
        eoc_flag <= 1'b0; // R14
      end else if (state == ST_CV && next_state == ST_EOC) begin
        eoc_flag <= 1'b1; // R14 R17
      end else if (next_state == ST_CC || next_state == ST_TRICKLE) begin
        // a fresh cycle, resumed or restarted, is no longer terminated
        eoc_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // status decode straight from the sequencer
  assign charging_active_flag = (state == ST_TRICKLE) || (state == ST_CC) ||
                                (state == ST_CV); // R11
  assign trickle_flag = (state == ST_TRICKLE); // R12
  assign topoff_mode_flag = (state == ST_CV); // R13

  ccsr_battery_absent_flag #(
    .BATTERY_ABSENT_FLAG_CYCLES(BATTERY_ABSENT_FLAG_CYCLES)
  ) u_battery_absent_flag (
    .clk(clk),
    .rst(rst),
    .eoc_start(state == ST_CV && next_state == ST_EOC),
    .vbat_drop(vbat_drop),
    .charge_enable(charge_enable),
    .battery_absent_flag(battery_absent_flag)
  );

  ////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe; unused and
  // unmapped bits read zero
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `CCSR_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= `CCSR_ZERO8; // R20
      case (reg_addr)
        `CCSR_ADDR_TERM_ADJ: begin
          reg_rdata[`CCSR_ADJ_HI:`CCSR_ADJ_LO] <= termination_current_adj;
        end
        `CCSR_ADDR_CTRL_PRI: begin
          reg_rdata[`CCSR_PRI_EN_BIT] <= charge_enable;
          reg_rdata[`CCSR_PRI_CC_HI:`CCSR_PRI_CC_LO] <= cc_current_sel;
          reg_rdata[`CCSR_PRI_PRE_HI:`CCSR_PRI_PRE_LO] <= precharge_current_sel;
          reg_rdata[`CCSR_PRI_OVPEN_BIT] <= ovp_enable;
        end
        `CCSR_ADDR_CTRL_SEC: begin
          reg_rdata[`CCSR_SEC_RESDIS_BIT] <= resume_disable;
          reg_rdata[`CCSR_SEC_HITERM_BIT] <= high_term_voltage_sel;
          reg_rdata[`CCSR_SEC_OVPHI_BIT] <= ovp_high_threshold_sel;
          reg_rdata[`CCSR_SEC_OVP_BIT] <= ovp_flag; // R9
        end
        `CCSR_ADDR_FLAGS: begin
          reg_rdata[`CCSR_ST_ADAPTER_BIT] <= adapter_present_flag; // R10
          reg_rdata[`CCSR_ST_ACTIVE_BIT] <= charging_active_flag; // R11
          reg_rdata[`CCSR_ST_TRICKLE_BIT] <= trickle_flag; // R12
          reg_rdata[`CCSR_ST_TOPOFF_BIT] <= topoff_mode_flag; // R13
          reg_rdata[`CCSR_ST_EOC_BIT] <= eoc_flag; // R14
          reg_rdata[`CCSR_ST_BATTERY_ABSENT_FLAG_BIT] <= battery_absent_flag; // R15
        end
        default: begin
          reg_rdata <= `CCSR_ZERO8;
        end
      endcase
    end
  end
endmodule // ccsr_top

// *** ccsr_defs.vh ***
`ifndef CCSR_DEFS_VH
`define CCSR_DEFS_VH

// register offsets on the control port
`define CCSR_ADDR_TERM_ADJ 8'h10
`define CCSR_ADDR_CTRL_PRI 8'h14
`define CCSR_ADDR_CTRL_SEC 8'h16
`define CCSR_ADDR_FLAGS 8'h35

// primary control fields
`define CCSR_PRI_EN_BIT 0
`define CCSR_PRI_CC_HI 4
`define CCSR_PRI_CC_LO 1
`define CCSR_PRI_PRE_HI 6
`define CCSR_PRI_PRE_LO 5
`define CCSR_PRI_OVPEN_BIT 7

// termination adjust field
`define CCSR_ADJ_HI 3
`define CCSR_ADJ_LO 2

// secondary control fields
`define CCSR_SEC_RESDIS_BIT 3
`define CCSR_SEC_HITERM_BIT 4
`define CCSR_SEC_OVPHI_BIT 6
`define CCSR_SEC_OVP_BIT 7

// status flag positions
`define CCSR_ST_ADAPTER_BIT 0
`define CCSR_ST_ACTIVE_BIT 1
`define CCSR_ST_TRICKLE_BIT 3
`define CCSR_ST_TOPOFF_BIT 4
`define CCSR_ST_EOC_BIT 5
`define CCSR_ST_BATTERY_ABSENT_FLAG_BIT 6

// reset values
`define CCSR_RST_EN 1'h1
`define CCSR_RST_OVPEN 1'h1
`define CCSR_RST_ADJ 2'h0
`define CCSR_RST_RESDIS 1'h0
`define CCSR_RST_HITERM 1'h1
`define CCSR_RST_OVPHI 1'h1
`define CCSR_ZERO8 8'h00

// timing: times in their own unit, clock in kHz
`define CCSR_CLK_KHZ 25000
`define CCSR_DEAD_TIME_MS 100
`define CCSR_BATTERY_ABSENT_FLAG_TIME_MS 2000
`define CCSR_BATTERY_ABSENT_FLAG_REPEATS 2'h2
`define CCSR_TMR_W 26

// analog input vector positions
`define CCSR_IN_W 7
`define CCSR_IN_ADAPTER 0
`define CCSR_IN_UVLO 1
`define CCSR_IN_TERMV 2
`define CCSR_IN_ILOW 3
`define CCSR_IN_OVP 4
`define CCSR_IN_VDROP 5
`define CCSR_IN_BATOK 6

`endif

// *** ccsr_sync.v ***
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of asynchronous comparator levels
module ccsr_sync #(
  parameter W = 7
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  ////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta; // first stage, read only by the second
      reg stable; // second stage, safe for logic
      // each bit crosses on its own; bits may settle one cycle apart
      always @(posedge clk) begin
        if (rst) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate
endmodule // ccsr_sync

// *** ccsr_battery_absent_flag.v ***
`timescale 1ns/1ps
`include "ccsr_defs.vh"
// no-battery detection: times each end-of-charge until the voltage drop
module ccsr_battery_absent_flag #(
  parameter [`CCSR_TMR_W-1:0] BATTERY_ABSENT_FLAG_CYCLES = `CCSR_BATTERY_ABSENT_FLAG_TIME_MS * `CCSR_CLK_KHZ
) (
  input wire clk,
  input wire rst,
  input wire eoc_start,
  input wire vbat_drop,
  input wire charge_enable,
  output reg battery_absent_flag
);
  ////////////////////////////////////////////////////////////////
  reg running; // timer armed since end of charge
  reg [`CCSR_TMR_W-1:0] elapsed; // cycles since end of charge
  reg [1:0] short_runs; // consecutive drops inside the window
  wire expired = (elapsed >= BATTERY_ABSENT_FLAG_CYCLES);

  // timer, run counter and flag; disable wins over everything
  always @(posedge clk) begin
    if (rst || !charge_enable) begin
      running <= 1'b0;
      elapsed <= {`CCSR_TMR_W{1'b0}};
      short_runs <= 2'h0;
      battery_absent_flag <= 1'b0; // R15
    end else if (eoc_start) begin
      running <= 1'b1;
      elapsed <= {`CCSR_TMR_W{1'b0}};
    end else if (running) begin
      if (vbat_drop && !expired) begin
        // quick collapse: counts toward a missing battery
        running <= 1'b0;
        if (short_runs == `CCSR_BATTERY_ABSENT_FLAG_REPEATS - 2'h1) begin
          battery_absent_flag <= 1'b1; // R19
          short_runs <= `CCSR_BATTERY_ABSENT_FLAG_REPEATS;
        end else if (short_runs != `CCSR_BATTERY_ABSENT_FLAG_REPEATS) begin
          short_runs <= short_runs + 2'h1;
        end
      end else if (expired) begin
        // voltage held past the window: a battery is present
        running <= 1'b0;
        short_runs <= 2'h0;
        battery_absent_flag <= 1'b0; // R15 R19
      end else begin
        elapsed <= elapsed + {{(`CCSR_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ccsr_battery_absent_flag

// *** ccsr_host.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// host side of the register port: one strobe per access, never both at once
module ccsr_host (
  input wire clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  // idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; the adjust field is never given the forbidden code 10
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand in the cycle after the strobe; take them at the edge that closes
  // that cycle, so every later stimulus stays aligned to rising edges
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // ccsr_host

// *** ccsr_chk.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// port-level checks of the charger register block
module ccsr_chk (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire charger_on,
  input wire [3:0] cc_current_sel,
  input wire [1:0] precharge_current_sel,
  input wire [1:0] termination_current_adj,
  input wire ovp_enable,
  input wire high_term_voltage_sel,
  input wire ovp_high_threshold_sel,
  input wire ovp_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // control fields come out of reset at their documented values
  property p_rst;
    $past(rst) |-> ovp_enable && high_term_voltage_sel && ovp_high_threshold_sel
      && termination_current_adj == 2'h0 && !charger_on;
  endproperty
  // first cycle after reset is skipped: the otp load wins there
  property p_wr_pri;
    reg_wr && reg_addr == 8'h14 && !$past(rst) |=>
      {ovp_enable, precharge_current_sel, cc_current_sel, 1'b0} == ($past(reg_wdata) & 8'hFE);
  endproperty
  property p_wr_adj;
    reg_wr && reg_addr == 8'h10 |=> {4'h0, termination_current_adj, 2'h0} == ($past(reg_wdata) & 8'h0C);
  endproperty
  property p_wr_sec;
    reg_wr && reg_addr == 8'h16 |=>
      {1'b0, ovp_high_threshold_sel, 1'b0, high_term_voltage_sel, 4'h0} == ($past(reg_wdata) & 8'h50);
  endproperty
  // clearing the enable stops charging one edge after it lands
  property p_dis;
    reg_wr && reg_addr == 8'h14 && !reg_wdata[0] |-> ##2 !charger_on;
  endproperty
  property p_unmap;
    reg_rd && !(reg_addr inside {8'h10, 8'h14, 8'h16, 8'h35}) |=> reg_rdata == 8'h00;
  endproperty
  property p_rsv;
    reg_rd && reg_addr == 8'h16 |=> reg_rdata[5] == 1'b0 && reg_rdata[2:0] == 3'h0;
  endproperty
  // the pulse trails the trip by one edge, and software may clear the enable meanwhile
  property p_ovp_en;
    ovp_event |-> $past(ovp_enable);
  endproperty
  property p_ovp_stop;
    ovp_event |=> !charger_on && !ovp_event;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_wr_pri: assert property (p_wr_pri) else $error("primary write not taken");
  a_wr_adj: assert property (p_wr_adj) else $error("adjust write not taken");
  a_wr_sec: assert property (p_wr_sec) else $error("secondary write not taken");
  a_dis: assert property (p_dis) else $error("charger still on after disable");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  a_ovp_en: assert property (p_ovp_en) else $error("trip without protection");
  a_ovp_stop: assert property (p_ovp_stop) else $error("trip did not stop charger");
  // main scenarios reached
  c_ovp: cover property (ovp_event);
  c_on: cover property ($rose(charger_on));
  c_battery_absent_flag: cover property (reg_rd && reg_addr == 8'h35 ##1 reg_rdata[6]);
endmodule // ccsr_chk
bind ccsr_top ccsr_chk ccsr_chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .charger_on(charger_on),
  .cc_current_sel(cc_current_sel), .precharge_current_sel(precharge_current_sel),
  .termination_current_adj(termination_current_adj), .ovp_enable(ovp_enable),
  .high_term_voltage_sel(high_term_voltage_sel), .ovp_high_threshold_sel(ovp_high_threshold_sel),
  .ovp_event(ovp_event));

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h expected %h", $time, a, e); end end
////////////////////////////////////////////////////////////
module testbench;
  logic clk, rst, adapter, uvlo, termv, ilow, ov, drop, charger_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  int failures = 0;
  int comparisons = 0;
  // short counts so resume and no-battery timing fit the run
  ccsr_top #(.DEAD_CYCLES(26'h14), .BATTERY_ABSENT_FLAG_CYCLES(26'h0C8)) ccsr_top_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .otp_cc_current_sel(4'hA), .otp_precharge_current_sel(2'h2), .adapter_detect_in(adapter),
    .vbat_below_uvlo_in(uvlo), .vbat_at_term_in(termv), .current_at_term_in(ilow),
    .overvoltage_in(ov), .vbat_resume_low_in(drop), .battery_ok_in(1'b1), .charger_on(charger_on),
    .cc_current_sel(), .precharge_current_sel(), .termination_current_adj(), .ovp_enable(),
    .high_term_voltage_sel(), .ovp_high_threshold_sel(), .ovp_event());
  ccsr_host ccsr_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    ccsr_host_i.rd(a, d);
    `CHK(d, e)
  endtask
  // comparator levels need two sync stages plus a state edge
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  // top-off, end of charge, then a quick drop that resumes charging
  task automatic charge_cycle(input logic [7:0] after);
    termv <= 1'b1;
    settle();
    chk(8'h35, 8'h13);
    ilow <= 1'b1;
    settle();
    chk(8'h35, 8'h21);
    termv <= 1'b0;
    ilow <= 1'b0;
    drop <= 1'b1;
    settle();
    drop <= 1'b0;
    repeat (30) @(posedge clk);
    chk(8'h35, after);
  endtask
  initial begin
    rst = 1'b1;
    {adapter, uvlo, termv, ilow, ov, drop} = 6'h10;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values, otp defaults, reserved and unmapped places
    chk(8'h14, 8'hD5);
    chk(8'h10, 8'h00);
    chk(8'h16, 8'h50);
    chk(8'h21, 8'h00);
    ccsr_host_i.wr(8'h14, 8'hFE);
    chk(8'h14, 8'hFE);
    ccsr_host_i.wr(8'h10, 8'hFF);
    chk(8'h10, 8'h0C);
    ccsr_host_i.wr(8'h16, 8'hFF);
    chk(8'h16, 8'h58);
    ccsr_host_i.wr(8'h35, 8'hFF);
    ccsr_host_i.wr(8'h21, 8'hFF);
    chk(8'h35, 8'h00);
    chk(8'h21, 8'h00);
    // adapter on a flat battery: trickle first, then constant current
    ccsr_host_i.wr(8'h16, 8'h50);
    ccsr_host_i.wr(8'h14, 8'h83);
    adapter <= 1'b1;
    settle();
    chk(8'h35, 8'h0B);
    `CHK(charger_on, 1'b1)
    uvlo <= 1'b0;
    settle();
    chk(8'h35, 8'h03);
    // two quick resumes in a row flag a missing battery
    charge_cycle(8'h03);
    charge_cycle(8'h43);
    termv <= 1'b1;
    ilow <= 1'b1;
    settle();
    chk(8'h35, 8'h61);
    ccsr_host_i.wr(8'h14, 8'h82);
    settle();
    chk(8'h35, 8'h01);
    // with resume off the drop leaves the charger parked at end of charge
    ccsr_host_i.wr(8'h16, 8'h58);
    ccsr_host_i.wr(8'h14, 8'h83);
    settle();
    termv <= 1'b0;
    ilow <= 1'b0;
    drop <= 1'b1;
    settle();
    drop <= 1'b0;
    repeat (30) @(posedge clk);
    chk(8'h35, 8'h21);
    ccsr_host_i.wr(8'h14, 8'h82);
    settle();
    chk(8'h35, 8'h01);
    // overvoltage trips the enable only while protection is on
    ccsr_host_i.wr(8'h16, 8'h10);
    ccsr_host_i.wr(8'h14, 8'h83);
    ov <= 1'b1;
    settle();
    chk(8'h16, 8'h90);
    chk(8'h14, 8'h82);
    ov <= 1'b0;
    ccsr_host_i.wr(8'h14, 8'h03);
    ov <= 1'b1;
    settle();
    chk(8'h14, 8'h03);
    ov <= 1'b0;
    stop_test();
  end
endmodule // testbench
